// ==== hw/jtap_top.sv ====
// Boundary-scan test access port: controller, instruction and data
// registers on the test clock, and a core-clock side that drives the
// queue pins. Assumes TCK, TMS, TDI and TRST_N come from an outside
// test controller, and that BS_CAPTURE are core pin levels.
`timescale 1ns/10ps
`default_nettype none
// Contract
// RL1: Four test inputs, one serial output
// RL2: State changes on rising test clock by select
// RL3: Five ones on select reach Test-Logic-Reset
// RL4: Test-Logic-Reset disables all test logic
// RL5: Test control overrides queue logic when active
// RL6: Power-up self reset; test reset optional
// RL7: Run-Test-Idle runs logic only if instructed
// RL8: Select-DR branches to data path or Select-IR
// RL9: Select-IR branches to IR path or reset
// RL10: Capture-IR loads pattern ending binary 01
// RL11: Shift-IR shifts instruction one bit per edge
// RL12: Exit1-IR goes to Pause-IR or Update-IR
// RL13: Pause-IR holds the instruction shift stages
// RL14: Exit2-IR returns to Shift-IR or Update-IR
// RL15: Update-IR latches instruction on falling edge
// RL16: Capture-DR loads selected data register
// RL17: Data path states mirror the instruction path
// RL18: Instruction register is four bits wide
// RL19: Decode EXTEST, SAMPLE, IDCODE, HIGHZ, BYPASS codes
// RL20: Bypass stage captures zero in Capture-DR
// RL21: Serial output falls-edge driven, only while shifting
module jtap_top import jtap_pkg::*; #(
    parameter int BSR_W = 8,
    parameter logic [31:0] ID_VALUE = 32'h1234_5671 // Arbitrary value
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    input wire logic TRST_N,
    output logic TDO_O,
    output logic TDO_OE,
    input wire logic [BSR_W-1:0] BS_CAPTURE,
    output logic [BSR_W-1:0] BS_DRIVE,
    output logic QUEUE_OVERRIDE,
    output logic OUTPUTS_HIGHZ
);

    // ---------------- Core clock side ----------------

    logic core_rst_q; // Core reset, registered for the test domain
    logic core_rst_d;

    // Reset request handed to the test domain
    always_comb begin
        core_rst_d = RST;
    end

    always_ff @(posedge CORE_CLK) begin
        core_rst_q <= core_rst_d;
    end

    // ---------------- Test clock side: reset ----------------

    logic trst_s1_q; // Test reset pin, first stage
    logic trst_s2_q; // Test reset pin, second stage
    logic crst_s1_q; // Core reset, first stage
    logic crst_s2_q; // Core reset, second stage
    logic trst_s1_d;
    logic crst_s1_d;
    logic tck_rst; // Combined synchronous reset of the test domain

    // Power-up reset and the optional pin both reset the port;
    // the pin may be held low or left high and unused
    always_comb begin
        trst_s1_d = ~TRST_N; // RL6
        crst_s1_d = core_rst_q; // RL6
    end

    always_ff @(posedge TCK) begin
        trst_s1_q <= trst_s1_d;
        trst_s2_q <= trst_s1_q;
        crst_s1_q <= crst_s1_d;
        crst_s2_q <= crst_s1_q;
    end

    // Needs a few test-clock edges to take effect, since the test
    // clock may stand still; five ones on select also reach reset
    assign tck_rst = trst_s2_q | crst_s2_q;

    // ---------------- Test clock side: controller ----------------

    jtap_state_t state_q; // Controller state
    jtap_state_t state_d;

    // Next state from the select level at each rising edge
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            JTAP_TLR: begin
                // Select high stays here: fifth one lands here too
                state_d = TMS ? JTAP_TLR : JTAP_RTI; // RL3
            end
            JTAP_RTI: begin
                // No self-test code exists, so nothing runs here
                state_d = TMS ? JTAP_SEL_DR : JTAP_RTI; // RL7
            end
            JTAP_SEL_DR: begin
                state_d = TMS ? JTAP_SEL_IR : JTAP_CAP_DR; // RL8
            end
            JTAP_CAP_DR: begin
                state_d = TMS ? JTAP_EX1_DR : JTAP_SH_DR; // RL17
            end
            JTAP_SH_DR: begin
                state_d = TMS ? JTAP_EX1_DR : JTAP_SH_DR; // RL17
            end
            JTAP_EX1_DR: begin
                state_d = TMS ? JTAP_UPD_DR : JTAP_PA_DR; // RL17
            end
            JTAP_PA_DR: begin
                state_d = TMS ? JTAP_EX2_DR : JTAP_PA_DR; // RL17
            end
            JTAP_EX2_DR: begin
                state_d = TMS ? JTAP_UPD_DR : JTAP_SH_DR; // RL17
            end
            JTAP_UPD_DR: begin
                state_d = TMS ? JTAP_SEL_DR : JTAP_RTI; // RL17
            end
            JTAP_SEL_IR: begin
                state_d = TMS ? JTAP_TLR : JTAP_CAP_IR; // RL9
            end
            JTAP_CAP_IR: begin
                state_d = TMS ? JTAP_EX1_IR : JTAP_SH_IR;
            end
            JTAP_SH_IR: begin
                state_d = TMS ? JTAP_EX1_IR : JTAP_SH_IR; // RL11
            end
            JTAP_EX1_IR: begin
                state_d = TMS ? JTAP_UPD_IR : JTAP_PA_IR; // RL12
            end
            JTAP_PA_IR: begin
                state_d = TMS ? JTAP_EX2_IR : JTAP_PA_IR; // RL13
            end
            JTAP_EX2_IR: begin
                state_d = TMS ? JTAP_UPD_IR : JTAP_SH_IR; // RL14
            end
            JTAP_UPD_IR: begin
                state_d = TMS ? JTAP_SEL_DR : JTAP_RTI;
            end
        endcase
    end

    // All state changes happen on the rising test-clock edge
    always_ff @(posedge TCK) begin
        if (tck_rst) begin
            state_q <= JTAP_TLR;
        end else begin
            state_q <= state_d; // RL2
        end
    end

    // ---------------- Instruction register ----------------

    logic [JTAP_IR_W-1:0] ir_sr; // Instruction shift stages
    logic [JTAP_IR_W-1:0] ir_cur; // Current instruction (hold latches)
    logic ir_rst; // Instruction reset, also in Test-Logic-Reset
    jtap_dsel_t dsel; // Data register picked by the instruction

    // Test-Logic-Reset forces the instruction back to a harmless one
    assign ir_rst = tck_rst | (state_q == JTAP_TLR); // RL4

    // Four-bit bank; shift stages freeze outside capture and shift
    jtap_shreg #(
        .W(JTAP_IR_W), // RL18
        .RST_VAL(JTAP_IR_RESET)
    ) u_ir (
        .tck(TCK),
        .rst(ir_rst),
        .capture_en(state_q == JTAP_CAP_IR), // RL10
        .shift_en(state_q == JTAP_SH_IR), // RL11
        .update_en(state_q == JTAP_UPD_IR), // RL15
        .capture_val(JTAP_IR_CAPTURE),
        .si(TDI),
        .sr_q(ir_sr),
        .hold_q(ir_cur)
    );

    assign dsel = jtap_decode(ir_cur); // RL19

    // ---------------- Data registers ----------------

    logic [BSR_W-1:0] pin_s1_q; // Core pins, first stage
    logic [BSR_W-1:0] pin_s2_q; // Core pins, second stage
    logic [BSR_W-1:0] pin_s1_d;
    logic [BSR_W-1:0] bsr_sr; // Boundary shift stages
    logic [BSR_W-1:0] bsr_hold; // Boundary update latches
    logic [JTAP_ID_W-1:0] id_sr; // Identification shift stages
    logic byp_q; // One-bit bypass stage
    logic byp_d;
    logic cap_dr; // Data capture state
    logic sh_dr; // Data shift state

    assign cap_dr = (state_q == JTAP_CAP_DR);
    assign sh_dr = (state_q == JTAP_SH_DR);

    // Pins come from another clock; bits may skew by one test clock,
    // acceptable for a sample of slow boundary levels
    always_comb begin
        pin_s1_d = BS_CAPTURE;
    end

    always_ff @(posedge TCK) begin
        pin_s1_q <= pin_s1_d;
        pin_s2_q <= pin_s1_q;
    end

    // Boundary register for the two boundary instructions
    jtap_shreg #(
        .W(BSR_W),
        .RST_VAL('0)
    ) u_bsr (
        .tck(TCK),
        .rst(tck_rst),
        .capture_en(cap_dr && dsel == JTAP_DSEL_BSR), // RL16
        .shift_en(sh_dr && dsel == JTAP_DSEL_BSR), // RL17
        .update_en(state_q == JTAP_UPD_DR && dsel == JTAP_DSEL_BSR),
        .capture_val(pin_s2_q),
        .si(TDI),
        .sr_q(bsr_sr),
        .hold_q(bsr_hold)
    );

    // Read-only identification register; its update is unused
    jtap_shreg #(
        .W(JTAP_ID_W),
        .RST_VAL(ID_VALUE)
    ) u_id (
        .tck(TCK),
        .rst(tck_rst),
        .capture_en(cap_dr && dsel == JTAP_DSEL_ID), // RL16
        .shift_en(sh_dr && dsel == JTAP_DSEL_ID), // RL17
        .update_en(1'b0),
        .capture_val(ID_VALUE),
        .si(TDI),
        .sr_q(id_sr),
        .hold_q()
    );

    // Bypass stage: zero on capture, one bit of delay while shifting
    always_comb begin
        byp_d = byp_q;
        if (dsel == JTAP_DSEL_BYP) begin
            if (cap_dr) begin
                byp_d = JTAP_BYP_CAPTURE; // RL20
            end else if (sh_dr) begin
                byp_d = TDI;
            end
        end
    end

    always_ff @(posedge TCK) begin
        if (tck_rst) begin
            byp_q <= JTAP_BYP_CAPTURE;
        end else begin
            byp_q <= byp_d;
        end
    end

    // ---------------- Serial output ----------------

    logic tdo_q; // Serial output level
    logic tdo_oe_q; // Serial output enable
    logic tdo_d;
    logic tdo_oe_d;

    // Mux the active path; only the two shift states drive the pin
    always_comb begin
        tdo_d = tdo_q;
        tdo_oe_d = 1'b0;
        if (state_q == JTAP_SH_IR) begin
            tdo_d = ir_sr[0];
            tdo_oe_d = 1'b1; // RL21
        end else if (sh_dr) begin
            tdo_oe_d = 1'b1; // RL21
            unique case (dsel)
                JTAP_DSEL_BSR: tdo_d = bsr_sr[0];
                JTAP_DSEL_ID: tdo_d = id_sr[0];
                JTAP_DSEL_BYP: tdo_d = byp_q;
            endcase
        end
    end

    // Falling edge gives the far end half a period of setup
    always_ff @(negedge TCK) begin
        if (tck_rst) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q <= tdo_d; // RL21
            tdo_oe_q <= tdo_oe_d;
        end
    end

    assign TDO_O = tdo_q; // RL1
    assign TDO_OE = tdo_oe_q;

    // ---------------- Boundary update toward the core ----------------

    logic upd_tgl_q; // Flips once per boundary update
    logic upd_tgl_d;
    logic ext_t_q; // External-test decode, registered for crossing
    logic ext_t_d;
    logic hz_t_q; // High-impedance decode, registered for crossing
    logic hz_t_d;

    // Toggle after the latches were written; latches then stay still
    // for many test clocks, so the core may copy them as a word.
    // Decodes go through flops so that a glitch of the multi-bit
    // compare never reaches the core-side synchronisers
    always_comb begin
        upd_tgl_d = upd_tgl_q;
        ext_t_d = (ir_cur == JTAP_OP_EXTEST);
        hz_t_d = (ir_cur == JTAP_OP_HIGHZ);
        if (state_q == JTAP_UPD_DR && dsel == JTAP_DSEL_BSR) begin
            upd_tgl_d = ~upd_tgl_q;
        end
    end

    always_ff @(posedge TCK) begin
        if (tck_rst) begin
            upd_tgl_q <= 1'b0;
            ext_t_q <= 1'b0;
            hz_t_q <= 1'b0;
        end else begin
            upd_tgl_q <= upd_tgl_d;
            ext_t_q <= ext_t_d;
            hz_t_q <= hz_t_d;
        end
    end

    // ---------------- Core side: crossings and pin control ----------

    logic [2:0] tgl_s_q; // Toggle synchroniser plus edge stage
    logic [2:0] tgl_s_d;
    logic ext_s1_q; // External-test level, first stage
    logic ext_s2_q;
    logic hz_s1_q; // High-impedance level, first stage
    logic hz_s2_q;
    logic ext_lvl; // External test instruction current
    logic hz_lvl; // High-impedance instruction current
    logic [BSR_W-1:0] drive_q; // Boundary levels for the pins
    logic [BSR_W-1:0] drive_d;

    // Levels leave flops in the test domain, one bit each
    assign ext_lvl = ext_t_q;
    assign hz_lvl = hz_t_q;

    // Next values of the core-side crossing and pin drive
    always_comb begin
        tgl_s_d = {tgl_s_q[1:0], upd_tgl_q};
        drive_d = drive_q;
        // Edge seen between second and third stages only
        if (tgl_s_q[2] != tgl_s_q[1]) begin
            drive_d = bsr_hold;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            tgl_s_q <= 3'h0;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            hz_s1_q <= 1'b0;
            hz_s2_q <= 1'b0;
            drive_q <= '0;
        end else begin
            tgl_s_q <= tgl_s_d;
            ext_s1_q <= ext_lvl;
            ext_s2_q <= ext_s1_q;
            hz_s1_q <= hz_lvl;
            hz_s2_q <= hz_s1_q;
            drive_q <= drive_d;
        end
    end

    // When QUEUE_OVERRIDE is set, the queue logic yields its pins to the boundary levels
    assign QUEUE_OVERRIDE = ext_s2_q; // RL5
    assign OUTPUTS_HIGHZ = hz_s2_q; // RL5
    assign BS_DRIVE = drive_q;

endmodule
`default_nettype wire

// ==== hw/jtap_pkg.sv ====
// Shared constants, types and decode for the boundary-scan test port.
// Assumes a four-bit instruction register and a one-bit bypass stage.
package jtap_pkg;

    // Instruction register width
    localparam int JTAP_IR_W = 4;
    // Identification register width
    localparam int JTAP_ID_W = 32;

    // Instruction codes
    localparam logic [3:0] JTAP_OP_EXTEST = 4'h0;
    localparam logic [3:0] JTAP_OP_SAMPLE = 4'h1;
    localparam logic [3:0] JTAP_OP_IDCODE = 4'h2;
    localparam logic [3:0] JTAP_OP_HIGHZ = 4'h3;
    localparam logic [3:0] JTAP_OP_BYPASS = 4'hF;

    // Pattern loaded into the instruction stages in the capture state
    localparam logic [3:0] JTAP_IR_CAPTURE = 4'h1;
    // Instruction held after any test-port reset
    localparam logic [3:0] JTAP_IR_RESET = JTAP_OP_IDCODE;
    // Value loaded into the bypass stage in the data capture state
    localparam logic JTAP_BYP_CAPTURE = 1'b0;

    // Controller states
    typedef enum logic [3:0] {
        JTAP_TLR, JTAP_RTI,
        JTAP_SEL_DR, JTAP_CAP_DR, JTAP_SH_DR, JTAP_EX1_DR,
        JTAP_PA_DR, JTAP_EX2_DR, JTAP_UPD_DR,
        JTAP_SEL_IR, JTAP_CAP_IR, JTAP_SH_IR, JTAP_EX1_IR,
        JTAP_PA_IR, JTAP_EX2_IR, JTAP_UPD_IR
    } jtap_state_t;

    // Data register chosen by the current instruction
    typedef enum logic [1:0] {
        JTAP_DSEL_BSR, JTAP_DSEL_ID, JTAP_DSEL_BYP
    } jtap_dsel_t;

    // Decode an instruction into its data register; unknown codes bypass
    function automatic jtap_dsel_t jtap_decode(input logic [3:0] op);
        jtap_dsel_t sel;
        sel = JTAP_DSEL_BYP;
        if (op == JTAP_OP_EXTEST || op == JTAP_OP_SAMPLE) begin
            sel = JTAP_DSEL_BSR;
        end else if (op == JTAP_OP_IDCODE) begin
            sel = JTAP_DSEL_ID;
        end
        return sel;
    endfunction

endpackage

// ==== hw/jtap_shreg.sv ====
// Capture / shift / update register cell bank for the test port.
// Assumes tck is the link clock; update is taken on its falling edge.
`timescale 1ns/10ps
`default_nettype none
module jtap_shreg #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic tck,
    input wire logic rst,
    input wire logic capture_en,
    input wire logic shift_en,
    input wire logic update_en,
    input wire logic [W-1:0] capture_val,
    input wire logic si,
    output logic [W-1:0] sr_q,
    output logic [W-1:0] hold_q
);

    logic [W-1:0] sr_d; // Next shift stage contents
    logic [W-1:0] hold_d; // Next hold latch contents

    // Shift stages: capture wins over shift; otherwise hold (pause)
    always_comb begin
        sr_d = sr_q;
        if (capture_en) begin
            sr_d = capture_val;
        end else if (shift_en) begin
            // Bit zero sits nearest the serial output
            if (W > 1) begin
                sr_d = {si, sr_q[W-1:1]};
            end else begin
                sr_d = {W{si}};
            end
        end
    end

    always_ff @(posedge tck) begin
        if (rst) begin
            sr_q <= RST_VAL;
        end else begin
            sr_q <= sr_d;
        end
    end

    // Hold latches copy the shift stages in the update state
    always_comb begin
        hold_d = hold_q;
        if (update_en) begin
            hold_d = sr_q;
        end
    end

    // Falling edge keeps the new value clear of the rising-edge shift
    always_ff @(negedge tck) begin
        if (rst) begin
            hold_q <= RST_VAL;
        end else begin
            hold_q <= hold_d;
        end
    end

endmodule
`default_nettype wire

// ==== tb/jtap_top_chk.sv ====
// Port checker for the test access port top.
// Assumes it is bound to every jtap_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module jtap_top_chk #(
    parameter int BSR_W = 8
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    input wire logic TRST_N,
    input wire logic TDO_O,
    input wire logic TDO_OE,
    input wire logic [BSR_W-1:0] BS_CAPTURE,
    input wire logic [BSR_W-1:0] BS_DRIVE,
    input wire logic QUEUE_OVERRIDE,
    input wire logic OUTPUTS_HIGHZ
);
    // Select held high over five test-clock periods
    sequence s_five_ones;
        TMS [*5];
    endsequence
    // Enable rising at a falling edge means a shift state was entered
    sequence s_oe_rise;
        $rose(TDO_OE);
    endsequence
    // Select is sampled here as it stood at the rising edge before
    AST_RST5: assert property (@(negedge TCK) disable iff (RST)
        s_five_ones |-> !TDO_OE)
        else $error("serial output enabled after five select ones");
    AST_OE_ENTRY: assert property (@(negedge TCK)
        disable iff (RST || !TRST_N) s_oe_rise |-> !$past(TMS))
        else $error("shift entered with select high");
    AST_OE_EXIT: assert property (@(negedge TCK)
        disable iff (RST || !TRST_N) TDO_OE && TMS |=> !TDO_OE)
        else $error("shift not left with select high");
    AST_OE_HOLD: assert property (@(negedge TCK)
        disable iff (RST || !TRST_N) TDO_OE && !TMS |=> TDO_OE)
        else $error("shift left with select low");
    // Core clock is fast enough to see the test clock level
    AST_TDO_FALL: assert property (@(posedge CORE_CLK)
        disable iff (RST) $changed(TDO_O) |-> !TCK)
        else $error("serial output moved while test clock high");
    AST_OE_FALL: assert property (@(posedge CORE_CLK)
        disable iff (RST) $changed(TDO_OE) |-> !TCK)
        else $error("output enable moved while test clock high");
    // Core reset clears pin control one edge later
    AST_CORE_RST: assert property (@(posedge CORE_CLK)
        RST |=> (BS_DRIVE == '0 && !QUEUE_OVERRIDE && !OUTPUTS_HIGHZ))
        else $error("pin control not cleared by reset");
    // Pin levels are undefined until the test side has seen its reset
    AST_EXCL: assert property (@(posedge CORE_CLK)
        disable iff (RST || !TRST_N) !(QUEUE_OVERRIDE && OUTPUTS_HIGHZ))
        else $error("two instructions current at once");
endmodule
bind jtap_top jtap_top_chk #(.BSR_W(BSR_W)) chk_inst (
    .CORE_CLK(CORE_CLK), .RST(RST), .TCK(TCK), .TMS(TMS), .TDI(TDI),
    .TRST_N(TRST_N), .TDO_O(TDO_O), .TDO_OE(TDO_OE),
    .BS_CAPTURE(BS_CAPTURE), .BS_DRIVE(BS_DRIVE),
    .QUEUE_OVERRIDE(QUEUE_OVERRIDE), .OUTPUTS_HIGHZ(OUTPUTS_HIGHZ));
`default_nettype wire

// ==== tb/jtap_ctl_model.sv ====
// Model of the outside test controller driving the test pins.
// Assumes callers start each step on a core-clock falling edge.
`timescale 1ns/10ps
`default_nettype none
module jtap_ctl_model (
    output var logic tck,
    output var logic tms,
    output var logic tdi,
    output var logic trst_n,
    input wire logic tdo_o,
    input wire logic tdo_oe
);
    // Test clock stands low between steps; reset pin starts low
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b0;
    end
    // Optional reset pin level
    task automatic set_trst(input logic v);
        trst_n = v;
    endtask
    // One 160 ns period; pins move just after the falling edge
    task automatic step(input logic m, input logic d, output logic o);
        #1;
        tms = m;
        tdi = d;
        #79;
        // Undriven line reads as high impedance
        o = tdo_oe ? tdo_o : 1'bz;
        tck = 1'b1;
        #80;
        tck = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the test access port top.
// Assumes the controller model drives every test pin.
`timescale 1ns/10ps
`default_nettype none
module testbench import jtap_pkg::*;;
    localparam int BSR_W = 8;
    localparam logic [31:0] ID_V = 32'h5A5A_0F0F; // Arbitrary value
    logic core_clk, rst, tck, tms, tdi, trst_n, tdo_o, tdo_oe;
    logic [BSR_W-1:0] bs_capture, bs_drive;
    logic queue_override, outputs_highz;
    int err_count, total_checks, cycles;
    jtap_top #(.BSR_W(BSR_W), .ID_VALUE(ID_V)) jtap_top_inst (
        .CORE_CLK(core_clk), .RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi),
        .TRST_N(trst_n), .TDO_O(tdo_o), .TDO_OE(tdo_oe),
        .BS_CAPTURE(bs_capture), .BS_DRIVE(bs_drive),
        .QUEUE_OVERRIDE(queue_override), .OUTPUTS_HIGHZ(outputs_highz));
    jtap_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe));
    // Core clock, 4 ns period
    always #2 core_clk = ~core_clk;
    // Hang guard: the whole run needs about 14000 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            finish_test();
        end
    end
    // Compare and count
    task automatic check(input string nm, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Full scan from Run-Test-Idle back to Run-Test-Idle
    task automatic scan(input bit ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic t;
        dout = '0;
        ctl.step(1'b1, 1'b0, t);
        if (ir) begin
            ctl.step(1'b1, 1'b0, t);
        end
        ctl.step(1'b0, 1'b0, t);
        ctl.step(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            ctl.step(i == n - 1, din[i], t);
            dout[i] = t;
        end
        ctl.step(1'b1, 1'b0, t);
        ctl.step(1'b0, 1'b0, t);
    endtask
    // Core reset, then the optional test reset pin with the clock running
    task automatic do_reset;
        logic t;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        for (int i = 0; i < 4; i++) ctl.step(1'b1, 1'b0, t);
        ctl.set_trst(1'b1);
        for (int i = 0; i < 3; i++) ctl.step(1'b1, 1'b0, t);
        ctl.step(1'b0, 1'b0, t);
    endtask
    // After reset the identification register is selected
    task automatic t_idcode;
        logic [31:0] d;
        check("override", queue_override, 0);
        check("highz", outputs_highz, 0);
        scan(0, 32, '0, d);
        check("id", d, ID_V);
    endtask
    // Every instruction code, plus one undefined code
    task automatic t_codes;
        logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hF, 4'h7};
        logic [31:0] d, e;
        foreach (codes[k]) begin
            scan(1, 4, {28'h0, codes[k]}, d);
            check("ir capture", d, JTAP_IR_CAPTURE);
            scan(0, (codes[k] == 4'h2) ? 32 : BSR_W, 32'h0000_00C6, d);
            e = (codes[k] == 4'h2) ? ID_V : (codes[k] <= 4'h1) ?
                32'(bs_capture) : 32'h0000_008C;
            check("dr", d, e);
            if (codes[k] <= 4'h1) begin
                check("drive", bs_drive, 8'hC6);
            end
            check("override", queue_override, codes[k] == 4'h0);
            check("highz", outputs_highz, codes[k] == 4'h3);
        end
    endtask
    // Instruction load broken by a pause, then a bypass scan
    task automatic t_pause;
        logic [13:0] m = 14'h1923;
        logic [13:0] di = 14'h0C30;
        logic [13:0] q;
        logic [31:0] d;
        for (int i = 0; i < 14; i++) ctl.step(m[i], di[i], q[i]);
        check("ir out", {q[11], q[10], q[5], q[4]}, 4'h1);
        check("pause", {31'h0, q[7]}, {31'h0, 1'bz});
        scan(0, BSR_W, 32'h0000_00C6, d);
        check("bypass", d, 32'h0000_008C);
    endtask
    // Five select ones from mid-shift reach Test-Logic-Reset
    task automatic t_tms_reset;
        logic t;
        logic [31:0] d;
        scan(1, 4, 32'h0, d);
        check("override", queue_override, 1);
        ctl.step(1'b1, 1'b0, t);
        ctl.step(1'b0, 1'b0, t);
        ctl.step(1'b0, 1'b0, t);
        ctl.step(1'b0, 1'b1, t);
        for (int i = 0; i < 5; i++) ctl.step(1'b1, 1'b0, t);
        ctl.step(1'b0, 1'b0, t);
        check("override", queue_override, 0);
        scan(0, 32, '0, d);
        check("id", d, ID_V);
    endtask
    // Core reset in mid-run, test clock running, select held low:
    // only the core reset can bring the port back to its reset state
    task automatic t_core_reset;
        logic t;
        logic [31:0] d;
        scan(1, 4, 32'h0, d);
        check("override", queue_override, 1);
        @(negedge core_clk);
        rst = 1'b1;
        for (int i = 0; i < 3; i++) ctl.step(1'b0, 1'b0, t);
        @(negedge core_clk);
        rst = 1'b0;
        for (int i = 0; i < 3; i++) ctl.step(1'b0, 1'b0, t);
        check("override", queue_override, 0);
        check("drive", bs_drive, 0);
        scan(0, 32, '0, d);
        check("id", d, ID_V);
    endtask
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        bs_capture = 8'hA5;
        err_count = 0;
        total_checks = 0;
        cycles = 0;
        do_reset();
        t_idcode();
        t_codes();
        t_pause();
        t_tms_reset();
        t_core_reset();
        finish_test();
    end
endmodule
`default_nettype wire
